// [rtl/gas_pkg.sv]
// constants and types for the gated acquisition sequencer
package gas_pkg;
  // register byte addresses
  localparam logic [7:0] GAS_CTRL_OFS      = 8'h00;
  localparam logic [7:0] GAS_ON_TIME_OFS   = 8'h04;
  localparam logic [7:0] GAS_OFF_TIME_OFS  = 8'h08;
  localparam logic [7:0] GAS_CUR_ADDR_OFS  = 8'h0c;
  localparam logic [7:0] GAS_END_ADDR_OFS  = 8'h10;
  localparam logic [7:0] GAS_PLAN_CNT_OFS  = 8'h14;
  localparam logic [7:0] GAS_STATUS_OFS    = 8'h18;
  localparam logic [7:0] GAS_CONFIG_OFS    = 8'h1c;
  localparam logic [7:0] GAS_IRQ_STAT_OFS  = 8'h20;
  localparam logic [7:0] GAS_IRQ_CLR_OFS   = 8'h24;
  localparam logic [7:0] GAS_IRQ_EN_OFS    = 8'h28;
  localparam logic [7:0] GAS_SAMPLES_OFS   = 8'h2c;
  // command bits of the control register
  localparam int GAS_CMD_LEVEL_BIT = 0;
  localparam int GAS_CMD_EDGE_BIT  = 1;
  localparam int GAS_CMD_TIMER_BIT = 2;
  localparam int GAS_CMD_STOP_BIT  = 3;
  // interrupt bits
  localparam int GAS_IRQ_SAMPLE_BIT = 0;
  localparam int GAS_IRQ_DONE_BIT   = 1;
  localparam int GAS_IRQ_REJ_BIT    = 2;
  localparam int GAS_IRQ_W          = 3;
  // reset values
  localparam logic [31:0] GAS_ON_TIME_RST  = 32'h0000_4e20;
  localparam logic [31:0] GAS_OFF_TIME_RST = 32'h0000_4e20;
  localparam logic        GAS_GATE_POL_RST = 1'b1;
  // timing
  localparam int GAS_CLK_PERIOD_PS   = 5000;
  localparam int GAS_MICRO_PS        = 1000000;
  localparam int GAS_OFF_ZERO_NS     = 200;
  localparam int GAS_US_CYCLES       = GAS_MICRO_PS / GAS_CLK_PERIOD_PS;
  localparam int GAS_OFF_ZERO_CYCLES = (GAS_OFF_ZERO_NS * 1000) / GAS_CLK_PERIOD_PS;
  localparam int GAS_PRE_W           = 8;

  typedef enum logic [2:0] {
    GAS_MODE_OFF   = 3'b000,
    GAS_MODE_LEVEL = 3'b001,
    GAS_MODE_TIMER = 3'b010,
    GAS_MODE_EDGE  = 3'b011,
    GAS_MODE_HEX   = 3'b100
  } gas_mode_type;

  typedef enum logic [1:0] {
    GAS_TM_IDLE = 2'b00,
    GAS_TM_ON   = 2'b01,
    GAS_TM_OFF  = 2'b10
  } gas_tstate_type;
endpackage : gas_pkg

// [rtl/gas_sequencer.sv]
// gated acquisition sequencer: start modes, gate timer, stop, status and interrupts
//
// Design decisions made here: the register offsets and the strobed register port.
module gas_sequencer
  import gas_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int CNT_W  = 32
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // external gate and counter gate
  input  wire logic              gate_in,
  output logic                   count_en,
  // sample store stream toward the converter
  output logic                   store_pulse,
  output logic      [ADDR_W-1:0] store_addr,
  input  wire logic              conv_ack,
  // interrupt
  output logic                   irq
);

  gas_mode_type            mode_ff;
  gas_tstate_type          tstate_ff;
  logic [31:0]             on_time_ff;
  logic [31:0]             off_time_ff;
  logic [ADDR_W-1:0]       addr_ff;
  logic [ADDR_W-1:0]       end_addr_ff;
  logic [CNT_W-1:0]        plan_ff;
  logic [CNT_W-1:0]        samples_ff;
  logic [CNT_W-1:0]        pending_ff;
  logic                    pol_ff;
  logic                    gate_prev_ff;
  logic                    armed_ff;
  logic [GAS_PRE_W-1:0]    pre_ff;
  logic [31:0]             phase_ff;
  logic [GAS_IRQ_W-1:0]    irq_stat_ff;
  logic [GAS_IRQ_W-1:0]    irq_en_ff;
  logic [31:0]             rdata_ff;
  logic                    count_en_ff;
  logic                    store_ff;
  logic [ADDR_W-1:0]       store_addr_ff;
  logic                    irq_ff;

  logic                    wr_ctrl;
  logic                    cmd_level;
  logic                    cmd_edge;
  logic                    cmd_timer;
  logic                    cmd_stop;
  logic                    start_req;
  logic                    idle;
  logic                    gate_q;
  logic                    gate_fall;
  logic                    us_tick;
  logic                    on_end;
  logic                    off_end;
  logic                    sample_evt;
  logic                    last_sample;
  logic                    finish;
  logic [GAS_IRQ_W-1:0]    irq_evt;
  gas_mode_type            status_code;
  logic [31:0]             nxt_rdata;

  assign wr_ctrl   = reg_wr && (reg_addr == GAS_CTRL_OFS);
  assign cmd_level = wr_ctrl && reg_wdata[GAS_CMD_LEVEL_BIT];
  assign cmd_edge  = wr_ctrl && reg_wdata[GAS_CMD_EDGE_BIT];
  assign cmd_timer = wr_ctrl && reg_wdata[GAS_CMD_TIMER_BIT];
  assign cmd_stop  = wr_ctrl && reg_wdata[GAS_CMD_STOP_BIT];
  assign start_req = cmd_level || cmd_edge || cmd_timer;
  assign idle      = (mode_ff == GAS_MODE_OFF);

  // gate qualified by the programmed active sense
  assign gate_q    = pol_ff ? gate_in : ~gate_in;
  assign gate_fall = gate_prev_ff && !gate_q;

  // internal gate timer phase ends
  assign us_tick = (pre_ff == GAS_PRE_W'(GAS_US_CYCLES - 1));
  assign on_end  = (tstate_ff == GAS_TM_ON) && us_tick && (phase_ff <= 32'h0000_0001);
  assign off_end = (tstate_ff == GAS_TM_OFF) &&
                   ((off_time_ff == 32'h0000_0000) ?
                    (pre_ff == GAS_PRE_W'(GAS_OFF_ZERO_CYCLES - 1)) :
                    (us_tick && (phase_ff <= 32'h0000_0001)));

  always_comb begin
    sample_evt = 1'b0;
    case (mode_ff)
      GAS_MODE_LEVEL: sample_evt = gate_fall;
      GAS_MODE_EDGE:  sample_evt = armed_ff && gate_fall;
      GAS_MODE_TIMER: sample_evt = on_end;
      default:        sample_evt = 1'b0;
    endcase
  end

  assign last_sample = ((plan_ff != '0) && (samples_ff + CNT_W'(1) == plan_ff)) ||
                       (addr_ff == end_addr_ff);
  assign finish      = sample_evt && last_sample;

  // acquisition mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= GAS_MODE_OFF;
    end else if (cmd_stop || finish) begin
      mode_ff <= GAS_MODE_OFF;
    end else if (idle && start_req) begin
      if (cmd_level) begin
        mode_ff <= GAS_MODE_LEVEL;
      end else if (cmd_edge) begin
        mode_ff <= GAS_MODE_EDGE;
      end else begin
        mode_ff <= GAS_MODE_TIMER;
      end
    end
  end

  // gate history and edge-mode arming
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_prev_ff <= 1'b0;
      armed_ff     <= 1'b0;
    end else begin
      gate_prev_ff <= gate_q;
      if (mode_ff != GAS_MODE_EDGE || cmd_stop) begin
        armed_ff <= 1'b0;
      end else if (gate_fall) begin
        armed_ff <= 1'b1;
      end
    end
  end

  // internal gate timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tstate_ff <= GAS_TM_IDLE;
      pre_ff    <= '0;
      phase_ff  <= '0;
    end else if (cmd_stop || finish || (mode_ff != GAS_MODE_TIMER && !(idle && cmd_timer
                 && !cmd_level && !cmd_edge))) begin
      tstate_ff <= GAS_TM_IDLE;
      pre_ff    <= '0;
      phase_ff  <= '0;
    end else begin
      case (tstate_ff)
        GAS_TM_IDLE: begin
          tstate_ff <= GAS_TM_ON;
          pre_ff    <= '0;
          phase_ff  <= on_time_ff;
        end
        GAS_TM_ON: begin
          if (on_end) begin
            tstate_ff <= GAS_TM_OFF;
            pre_ff    <= '0;
            phase_ff  <= off_time_ff;
          end else if (us_tick) begin
            pre_ff   <= '0;
            phase_ff <= phase_ff - 32'h0000_0001;
          end else begin
            pre_ff <= pre_ff + GAS_PRE_W'(1);
          end
        end
        GAS_TM_OFF: begin
          if (off_end) begin
            tstate_ff <= GAS_TM_ON;
            pre_ff    <= '0;
            phase_ff  <= on_time_ff;
          end else if (us_tick) begin
            pre_ff   <= '0;
            phase_ff <= phase_ff - 32'h0000_0001;
          end else begin
            pre_ff <= pre_ff + GAS_PRE_W'(1);
          end
        end
        default: begin
          tstate_ff <= GAS_TM_IDLE;
          pre_ff    <= '0;
          phase_ff  <= '0;
        end
      endcase
    end
  end

  // counter gate
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_en_ff <= 1'b0;
    end else if (cmd_stop || finish) begin
      count_en_ff <= 1'b0;
    end else begin
      case (mode_ff)
        GAS_MODE_LEVEL: count_en_ff <= gate_q;
        GAS_MODE_EDGE:  count_en_ff <= armed_ff || gate_fall;
        GAS_MODE_TIMER: count_en_ff <= (tstate_ff == GAS_TM_ON) && !on_end && gate_q;
        default:        count_en_ff <= 1'b0;
      endcase
    end
  end

  // sample store and address walk
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      store_ff      <= 1'b0;
      store_addr_ff <= '0;
      addr_ff       <= '0;
      samples_ff    <= '0;
    end else begin
      store_ff <= sample_evt && !cmd_stop;
      if (sample_evt && !cmd_stop) begin
        store_addr_ff <= addr_ff;
        addr_ff       <= addr_ff + ADDR_W'(1);
        samples_ff    <= samples_ff + CNT_W'(1);
      end else if (reg_wr && reg_addr == GAS_CUR_ADDR_OFS && idle) begin
        addr_ff <= reg_wdata[ADDR_W-1:0];
      end
      if (idle && start_req) begin
        samples_ff <= '0;
      end
    end
  end

  // conversion backlog: stored samples not yet acknowledged by the converter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_ff <= '0;
    end else if (store_ff && !conv_ack) begin
      pending_ff <= pending_ff + CNT_W'(1);
    end else if (!store_ff && conv_ack && pending_ff != '0) begin
      pending_ff <= pending_ff - CNT_W'(1);
    end
  end

  // settings
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      on_time_ff  <= GAS_ON_TIME_RST;
      off_time_ff <= GAS_OFF_TIME_RST;
      end_addr_ff <= '1;
      plan_ff     <= '0;
      pol_ff      <= GAS_GATE_POL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        GAS_ON_TIME_OFS:  on_time_ff  <= reg_wdata;
        GAS_OFF_TIME_OFS: off_time_ff <= reg_wdata;
        GAS_END_ADDR_OFS: end_addr_ff <= reg_wdata[ADDR_W-1:0];
        GAS_PLAN_CNT_OFS: plan_ff     <= reg_wdata[CNT_W-1:0];
        GAS_CONFIG_OFS:   pol_ff      <= reg_wdata[0];
        default:          pol_ff      <= pol_ff;
      endcase
    end
  end

  // interrupts: set wins over clear
  assign irq_evt = {idle ? 1'b0 : start_req, finish || (cmd_stop && !idle), store_ff};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= '0;
      irq_en_ff   <= '0;
      irq_ff      <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == GAS_IRQ_CLR_OFS) begin
        irq_stat_ff <= (irq_stat_ff & ~reg_wdata[GAS_IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
      if (reg_wr && reg_addr == GAS_IRQ_EN_OFS) begin
        irq_en_ff <= reg_wdata[GAS_IRQ_W-1:0];
      end
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // status code
  always_comb begin
    if (!idle) begin
      status_code = mode_ff;
    end else if (pending_ff != '0 || store_ff) begin
      status_code = GAS_MODE_HEX;
    end else begin
      status_code = GAS_MODE_OFF;
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        GAS_ON_TIME_OFS:  nxt_rdata = on_time_ff;
        GAS_OFF_TIME_OFS: nxt_rdata = off_time_ff;
        GAS_CUR_ADDR_OFS: nxt_rdata = 32'(addr_ff);
        GAS_END_ADDR_OFS: nxt_rdata = 32'(end_addr_ff);
        GAS_PLAN_CNT_OFS: nxt_rdata = 32'(plan_ff);
        GAS_STATUS_OFS:   nxt_rdata = {25'h0, armed_ff, tstate_ff, pol_ff, status_code};
        GAS_CONFIG_OFS:   nxt_rdata = {31'h0, pol_ff};
        GAS_IRQ_STAT_OFS: nxt_rdata = {29'h0, irq_stat_ff};
        GAS_IRQ_EN_OFS:   nxt_rdata = {29'h0, irq_en_ff};
        GAS_SAMPLES_OFS:  nxt_rdata = 32'(samples_ff);
        default:          nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata   = rdata_ff;
  assign count_en    = count_en_ff;
  assign store_pulse = store_ff;
  assign store_addr  = store_addr_ff;
  assign irq         = irq_ff;

  // assertions
  sequence start_while_busy_s;
    !idle && start_req && !cmd_stop && !finish;
  endsequence

  sequence level_fall_s;
    (mode_ff == GAS_MODE_LEVEL) && gate_fall && !cmd_stop;
  endsequence

  reset_stopped_a: assert property (@(posedge clk) $rose(reset_n) |-> idle && !count_en)
    else $error("not stopped after reset");
  level_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    level_fall_s |=> store_pulse && store_addr == $past(addr_ff))
    else $error("level fall did not store");
  addr_walk_a: assert property (@(posedge clk) disable iff (!reset_n)
    store_pulse && !mode_ff[2] |-> addr_ff == store_addr + ADDR_W'(1))
    else $error("address not sequential");
  plan_end_a: assert property (@(posedge clk) disable iff (!reset_n)
    sample_evt && plan_ff != '0 && samples_ff + CNT_W'(1) == plan_ff |=> idle)
    else $error("plan count did not end acquisition");
  edge_closed_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode_ff == GAS_MODE_EDGE) && !armed_ff && !gate_fall |=> !count_en)
    else $error("edge gate opened early");
  stop_halt_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_stop |=> idle && !count_en ##1 !count_en)
    else $error("stop did not halt");
  off_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(tstate_ff == GAS_TM_OFF) && off_time_ff == '0 && mode_ff == GAS_MODE_TIMER
    && !cmd_stop |-> ##39 (tstate_ff != GAS_TM_ON) ##1 (tstate_ff != GAS_TM_OFF))
    else $error("zero off phase wrong length");
  busy_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
    start_while_busy_s |=> $stable(mode_ff))
    else $error("start accepted while busy");
  status_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    status_code == GAS_MODE_OFF |-> idle && pending_ff == '0 && tstate_ff == GAS_TM_IDLE
    && !count_en)
    else $error("inactive reported while busy");

endmodule : gas_sequencer

// [verification/gas_conv_model.sv]
// converter stand-in: acknowledges each stored sample after a set delay
module gas_conv_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // store stream
  input  wire logic       store_pulse,
  input  wire logic [7:0] ack_delay,
  output logic            conv_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  int pend_ff;
  int wait_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_ff  <= 0;
      wait_ff  <= 0;
      conv_ack <= 1'b0;
    end else if (pend_ff != 0 && wait_ff >= int'(ack_delay)) begin
      conv_ack <= 1'b1;
      wait_ff  <= 0;
      pend_ff  <= pend_ff - 1 + int'(store_pulse);
    end else begin
      conv_ack <= 1'b0;
      wait_ff  <= (pend_ff != 0) ? wait_ff + 1 : 0;
      pend_ff  <= pend_ff + int'(store_pulse);
    end
  end
endmodule : gas_conv_model

// [verification/tb.sv]
// self-checking bench for the gated acquisition sequencer
module tb
  import gas_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        gate_in   = 1'b0;
  logic [7:0]  ack_delay = 8'h02;
  logic [31:0] reg_rdata;
  logic [31:0] store_addr;
  logic        count_en;
  logic        store_pulse;
  logic        conv_ack;
  logic        irq;
  int          fails     = 0;
  int          checked   = 0;
  int          cycles    = 0;

  always #2.5 clk = ~clk;

  gas_sequencer dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gate_in(gate_in), .count_en(count_en), .store_pulse(store_pulse),
    .store_addr(store_addr), .conv_ack(conv_ack), .irq(irq));
  gas_conv_model conv (.clk(clk), .reset_n(reset_n), .store_pulse(store_pulse),
    .ack_delay(ack_delay), .conv_ack(conv_ack));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic gate(input logic v);
    @(posedge clk);
    gate_in <= v;
  endtask : gate

  task automatic wstore(input int n, input logic [31:0] a);
    for (int i = 0; i < n; i++) begin
      cyc(1);
      if (store_pulse === 1'b1) break;
    end
    chk({31'h0, store_pulse}, 32'h1);
    chk(store_addr, a);
  endtask : wstore

  task automatic t_reset();
    chk({29'h0, count_en, store_pulse, irq}, 32'h0);
    rchk(GAS_STATUS_OFS, 32'h7, 32'h0);
    rchk(GAS_ON_TIME_OFS, 32'hffffffff, GAS_ON_TIME_RST);
    rchk(GAS_OFF_TIME_OFS, 32'hffffffff, GAS_OFF_TIME_RST);
    wr(GAS_ON_TIME_OFS, 32'hffffffff);
    rchk(GAS_ON_TIME_OFS, 32'hffffffff, 32'hffffffff);
    wr(GAS_OFF_TIME_OFS, 32'hffffffff);
    rchk(GAS_OFF_TIME_OFS, 32'hffffffff, 32'hffffffff);
    rchk(8'h40, 32'hffffffff, 32'h0);
    rchk(GAS_CONFIG_OFS, 32'h1, 32'h1);
    gate(1'b1);
    gate(1'b0);
    cyc(4);
    chk({31'h0, count_en}, 32'h0);
    rchk(GAS_SAMPLES_OFS, 32'hffffffff, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_level();
    @(posedge clk);
    ack_delay <= 8'hc8;
    wr(GAS_CUR_ADDR_OFS, 32'h10);
    wr(GAS_PLAN_CNT_OFS, 32'h2);
    wr(GAS_IRQ_EN_OFS, 32'h1);
    wr(GAS_CTRL_OFS, 32'h1);
    rchk(GAS_STATUS_OFS, 32'h7, 32'h1);
    chk({31'h0, count_en}, 32'h0);
    for (int k = 0; k < 2; k++) begin
      gate(1'b1);
      cyc(4);
      chk({31'h0, count_en}, 32'h1);
      gate(1'b0);
      wstore(8, 32'h10 + 32'(k));
      cyc(3);
      chk({31'h0, count_en}, 32'h0);
      chk({31'h0, irq}, 32'h1);
    end
    rchk(GAS_STATUS_OFS, 32'h7, 32'h4);
    rchk(GAS_SAMPLES_OFS, 32'hffffffff, 32'h2);
    rchk(GAS_IRQ_STAT_OFS, 32'h2, 32'h2);
    wr(GAS_IRQ_EN_OFS, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rchk(GAS_IRQ_STAT_OFS, 32'h1, 32'h1);
    wr(GAS_IRQ_CLR_OFS, 32'h7);
    rchk(GAS_IRQ_STAT_OFS, 32'h7, 32'h0);
    cyc(600);
    rchk(GAS_STATUS_OFS, 32'h7, 32'h0);
    $display("test level done");
  endtask : t_level

  task automatic t_edge();
    @(posedge clk);
    ack_delay <= 8'h02;
    wr(GAS_END_ADDR_OFS, 32'h13);
    wr(GAS_PLAN_CNT_OFS, 32'h0);
    wr(GAS_CTRL_OFS, 32'h2);
    rchk(GAS_STATUS_OFS, 32'h7, 32'h3);
    gate(1'b1);
    cyc(4);
    chk({31'h0, count_en}, 32'h0);
    gate(1'b0);
    cyc(4);
    chk({31'h0, count_en}, 32'h1);
    rchk(GAS_SAMPLES_OFS, 32'hffffffff, 32'h0);
    for (int k = 0; k < 2; k++) begin
      gate(1'b1);
      cyc(3);
      gate(1'b0);
      wstore(8, 32'h12 + 32'(k));
    end
    cyc(20);
    rchk(GAS_STATUS_OFS, 32'h7, 32'h0);
    $display("test edge done");
  endtask : t_edge

  task automatic t_timer();
    int n;
    // on plus off kept far below the host's 10 ms floor so the run stays short
    wr(GAS_ON_TIME_OFS, 32'h1);
    wr(GAS_OFF_TIME_OFS, 32'h0);
    wr(GAS_END_ADDR_OFS, 32'hffffffff);
    rchk(GAS_ON_TIME_OFS, 32'hffffffff, 32'h1);
    rchk(GAS_OFF_TIME_OFS, 32'hffffffff, 32'h0);
    gate(1'b1);
    wr(GAS_CTRL_OFS, 32'h4);
    rchk(GAS_STATUS_OFS, 32'h7, 32'h2);
    cyc(20);
    chk({31'h0, count_en}, 32'h1);
    wstore(400, 32'h14);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (store_pulse !== 1'b1 && n < 400);
    // one us on phase plus the short off phase
    chk({31'h0, n >= 238 && n <= 244}, 32'h1);
    chk(store_addr, 32'h15);
    cyc(5);
    chk({31'h0, count_en}, 32'h0);
    cyc(60);
    chk({31'h0, count_en}, 32'h1);
    gate(1'b0);
    cyc(3);
    chk({31'h0, count_en}, 32'h0);
    // inverted sense: a low gate now qualifies
    wr(GAS_CONFIG_OFS, 32'h0);
    cyc(2);
    chk({31'h0, count_en}, 32'h1);
    wr(GAS_CONFIG_OFS, 32'h1);
    gate(1'b1);
    wr(GAS_CTRL_OFS, 32'h1);
    rchk(GAS_IRQ_STAT_OFS, 32'h4, 32'h4);
    rchk(GAS_STATUS_OFS, 32'h7, 32'h2);
    wr(GAS_CTRL_OFS, 32'h8);
    cyc(2);
    chk({31'h0, count_en}, 32'h0);
    cyc(10);
    rchk(GAS_STATUS_OFS, 32'h7, 32'h0);
    $display("test timer done");
  endtask : t_timer

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 0);
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_level();
    t_edge();
    t_timer();
    conclude();
  end
endmodule : tb
